// file: tdm_consts.svh
`ifndef TDM_CONSTS_SVH
`define TDM_CONSTS_SVH

// Data memory locations served by this block
`define TDM_A_IND0 8'h00
`define TDM_A_PTR0 8'h01
`define TDM_A_IND1 8'h02
`define TDM_A_PTR1 8'h03
`define TDM_A_BANK 8'h04
`define TDM_A_TBLP 8'h07
`define TDM_A_TAB_HIGH 8'h08
`define TDM_A_TBHP 8'h09
`define TDM_GP_BASE 8'h80

// Program memory
`define TDM_PM_WORDS 2048
`define TDM_PM_LAST_PAGE 11'h700

// Reset and fill values
`define TDM_RST_BYTE 8'h00
`define TDM_RD_NONE 8'h00

// Timing
`define TDM_CLKS_PER_ICYC 4
`define TDM_TAB_ICYC 2
`define TDM_TAB_CLKS (`TDM_CLKS_PER_ICYC * `TDM_TAB_ICYC)
`define TDM_PM_CAP_CNT 3'h1

`endif

// file: tdm_gp_ram.sv
`timescale 1ns/10ps
module tdm_gp_ram
    import tdm_pkg::*;
#(
    parameter int AW = 7,
    parameter int DEPTH = 128
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Access port
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);

    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
        $error("tdm_gp_ram: DEPTH does not fit AW");
    end

    logic [7:0] mem [DEPTH];
    tdm_mem_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.rdata = mem[i_addr];
    end

    // Contents are not cleared by reset, only the read register
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        if (i_srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata = s_reg.rdata;

endmodule

// file: tdm_pkg.sv
package tdm_pkg;

    typedef enum logic [1:0] {
        TDM_IDLE,
        TDM_RD,
        TDM_WR,
        TDM_TAB
    } tdm_state_t;

    typedef struct packed {
        tdm_state_t st;
        logic [2:0] cnt;
        logic bank;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bit_op;
        logic [2:0] bit_idx;
        logic bit_set;
        logic [7:0] rdata;
        logic acc_done;
        logic tab_done;
        logic [7:0] ptr0;
        logic [7:0] ptr1;
        logic bank_sel;
        logic [7:0] tblp;
        logic [2:0] tbhp;
        logic [6:0] tab_high;
        logic [10:0] pm_addr;
        logic pm_rd;
    } tdm_core_t;

    typedef struct packed {
        logic [7:0] rdata;
    } tdm_mem_t;

endpackage

// file: tdm_pm_model.sv
`timescale 1ns/10ps
module tdm_pm_model (
    // Clock
    input wire logic i_clk,
    // Read request from the block
    input wire logic i_rd,
    input wire logic [10:0] i_addr,
    // Word returned
    output logic [14:0] o_data
);
    initial o_data = 15'h2a5a;

    // Word content derived from its address; junk that flips every cycle otherwise,
    // so a late or early sample of the word never matches by luck
    always @(posedge i_clk) begin
        if (i_rd) begin
            o_data <= {i_addr[6:0], ~i_addr[7:0]};
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule

// file: tdm_table_mem.sv
// Operation
// - Table read loads word upper part into latch
// - Table read writes low byte to operand
// - Program address from both table pointer registers
// - Pointer spans 2K words, last page 700H
// - Table high latch ignores program writes
// - Table read lasts two instruction cycles
// - Byte-wide data memory, two banks, bank register
// - 00H-7FH special area, 80H-FFH general RAM
// - Some special locations are read-only
// - General RAM read/write, single-bit set/clear
// - Unused special locations read 00H
// - Direct and port0 bank 0; port1 any bank
// - Indirect port reached directly reads 00H, ignores writes
`timescale 1ns/10ps
`include "tdm_consts.svh"
module tdm_table_mem
    import tdm_pkg::*;
#(
    parameter int TAB_CLKS = `TDM_TAB_CLKS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Data memory access
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic [7:0] i_acc_addr,
    input wire logic [7:0] i_acc_wdata,
    input wire logic i_acc_bit,
    input wire logic [2:0] i_acc_bit_idx,
    input wire logic i_acc_bit_set,
    output logic o_acc_done,
    output logic [7:0] o_acc_rdata,
    // Table read
    input wire logic i_tab_start,
    input wire logic [7:0] i_tab_dest,
    output logic o_tab_done,
    // Program memory
    output logic [10:0] o_pm_addr,
    output logic o_pm_rd,
    input wire logic [14:0] i_pm_data,
    // Status
    output logic o_busy,
    output logic o_int_hold,
    output logic [6:0] o_table_high
);

    // Counter is three bits and the capture slot is fixed
    if (TAB_CLKS < 4 || TAB_CLKS > 8) begin : g_chk
        $error("tdm_table_mem: TAB_CLKS must lie in 4..8");
    end

    localparam logic [2:0] TAB_LAST = 3'(TAB_CLKS - 2);

    tdm_core_t s_reg, s_next;
    logic [7:0] mem_rdata;
    logic mem_we;
    logic [6:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [8:0] in_eff;
    logic [8:0] tab_eff;
    logic [8:0] s_eff;
    logic [7:0] rd_byte;
    logic take_acc;
    logic take_tab;

    // Bank and byte that an operand finally names
    function automatic logic [8:0] resolve(input logic [7:0] a, input tdm_core_t c);
        if (a == `TDM_A_IND0) begin
            resolve = {1'b0, c.ptr0};
        end else if (a == `TDM_A_IND1) begin
            resolve = {c.bank_sel, c.ptr1};
        end else begin
            resolve = {1'b0, a};
        end
    endfunction

    function automatic logic is_gp(input logic [8:0] e);
        is_gp = !e[8] && (e[7:0] >= `TDM_GP_BASE);
    endfunction

    // Indirect ports and unused special bytes fall to the default
    function automatic logic [7:0] sfr_rd(input logic [8:0] e, input tdm_core_t c);
        sfr_rd = `TDM_RD_NONE;
        if (!e[8]) begin
            case (e[7:0])
                `TDM_A_PTR0: sfr_rd = c.ptr0;
                `TDM_A_PTR1: sfr_rd = c.ptr1;
                `TDM_A_BANK: sfr_rd = {7'h00, c.bank_sel};
                `TDM_A_TBLP: sfr_rd = c.tblp;
                `TDM_A_TAB_HIGH: sfr_rd = {1'b0, c.tab_high};
                `TDM_A_TBHP: sfr_rd = {5'h00, c.tbhp};
                default: sfr_rd = `TDM_RD_NONE;
            endcase
        end
    endfunction

    // Latch and indirect ports have no write path
    function automatic tdm_core_t sfr_wr(input tdm_core_t c, input logic [8:0] e,
                                         input logic [7:0] d);
        sfr_wr = c;
        if (!e[8]) begin
            case (e[7:0])
                `TDM_A_PTR0: sfr_wr.ptr0 = d;
                `TDM_A_PTR1: sfr_wr.ptr1 = d;
                `TDM_A_BANK: sfr_wr.bank_sel = d[0];
                `TDM_A_TBLP: sfr_wr.tblp = d;
                `TDM_A_TBHP: sfr_wr.tbhp = d[2:0];
                default: ;
            endcase
        end
    endfunction

    assign in_eff = resolve(i_acc_addr, s_reg);
    assign tab_eff = resolve(i_tab_dest, s_reg);
    assign s_eff = {s_reg.bank, s_reg.addr};
    // A table read wins if both arrive together
    assign take_tab = (s_reg.st == TDM_IDLE) && i_tab_start;
    assign take_acc = (s_reg.st == TDM_IDLE) && i_acc_valid && !i_tab_start;

    always_comb begin
        s_next = s_reg;
        s_next.acc_done = 1'b0;
        s_next.tab_done = 1'b0;
        s_next.pm_rd = 1'b0;
        rd_byte = is_gp(s_eff) ? mem_rdata : sfr_rd(s_eff, s_reg);
        mem_we = 1'b0;
        mem_addr = in_eff[6:0];
        mem_wdata = i_acc_wdata;
        unique case (s_reg.st)
            TDM_IDLE: begin
                if (take_tab) begin
                    s_next.st = TDM_TAB;
                    s_next.cnt = 3'h0;
                    s_next.bank = tab_eff[8];
                    s_next.addr = tab_eff[7:0];
                    s_next.pm_addr = {s_reg.tbhp, s_reg.tblp};
                    s_next.pm_rd = 1'b1;
                end else if (take_acc) begin
                    s_next.bank = in_eff[8];
                    s_next.addr = in_eff[7:0];
                    s_next.wdata = i_acc_wdata;
                    s_next.bit_op = i_acc_bit;
                    s_next.bit_idx = i_acc_bit_idx;
                    s_next.bit_set = i_acc_bit_set;
                    if (i_acc_write && !i_acc_bit) begin
                        mem_we = is_gp(in_eff);
                        s_next = sfr_wr(s_next, in_eff, i_acc_wdata);
                        s_next.acc_done = 1'b1;
                    end else begin
                        s_next.st = TDM_RD;
                    end
                end
            end
            TDM_RD: begin
                if (s_reg.bit_op) begin
                    s_next.wdata = rd_byte;
                    s_next.wdata[s_reg.bit_idx] = s_reg.bit_set;
                    s_next.st = TDM_WR;
                end else begin
                    s_next.rdata = rd_byte;
                    s_next.acc_done = 1'b1;
                    s_next.st = TDM_IDLE;
                end
            end
            TDM_WR: begin
                mem_we = is_gp(s_eff);
                mem_addr = s_reg.addr[6:0];
                mem_wdata = s_reg.wdata;
                s_next = sfr_wr(s_next, s_eff, s_reg.wdata);
                s_next.rdata = s_reg.wdata;
                s_next.acc_done = 1'b1;
                s_next.st = TDM_IDLE;
            end
            TDM_TAB: begin
                s_next.cnt = s_reg.cnt + 3'h1;
                if (s_reg.cnt == `TDM_PM_CAP_CNT) begin
                    s_next.tab_high = i_pm_data[14:8];
                    mem_we = is_gp(s_eff);
                    mem_addr = s_reg.addr[6:0];
                    mem_wdata = i_pm_data[7:0];
                    s_next = sfr_wr(s_next, s_eff, i_pm_data[7:0]);
                end
                if (s_reg.cnt == TAB_LAST) begin
                    s_next.tab_done = 1'b1;
                    s_next.st = TDM_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Bank 1 holds no general RAM, so only bank 0 reaches the array
    tdm_gp_ram #(
        .AW(7),
        .DEPTH(128)
    ) u_ram (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    assign o_acc_done = s_reg.acc_done;
    assign o_acc_rdata = s_reg.rdata;
    assign o_tab_done = s_reg.tab_done;
    assign o_pm_addr = s_reg.pm_addr;
    assign o_pm_rd = s_reg.pm_rd;
    assign o_busy = (s_reg.st != TDM_IDLE);
    assign o_int_hold = (s_reg.st == TDM_TAB);
    assign o_table_high = s_reg.tab_high;

    // Helpers for checks
    localparam int TAB_DLY = TAB_CLKS;
    logic [6:0] pm_hi;
    logic [10:0] tptr;
    logic plain_rd;
    assign pm_hi = i_pm_data[14:8];
    assign tptr = {s_reg.tbhp, s_reg.tblp};
    assign plain_rd = take_acc && !i_acc_write && !i_acc_bit;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    tab_latch_a: assert property (o_tab_done |-> o_table_high == $past(pm_hi, 6))
        else $error("latch not loaded from fetched word");
    tab_dest_a: assert property (take_tab && is_gp(tab_eff)
        |-> ##2 (mem_we && s_eff == $past(tab_eff, 2) && mem_wdata == i_pm_data[7:0]))
        else $error("table low byte not written");
    pm_addr_a: assert property (take_tab |=> o_pm_rd && o_pm_addr == $past(tptr))
        else $error("program address not from table pointer");
    latch_ro_a: assert property (take_acc && i_acc_write && !i_acc_bit
        && in_eff == {1'b0, `TDM_A_TAB_HIGH} |=> $stable(o_table_high))
        else $error("latch changed by write");
    tab_len_a: assert property (take_tab |-> ##TAB_DLY o_tab_done)
        else $error("table read length wrong");
    hold_a: assert property (o_int_hold |=> (o_int_hold || o_tab_done))
        else $error("interrupt hold dropped early");
    ind0_bank_a: assert property (take_acc && i_acc_write && !i_acc_bit
        && i_acc_addr == `TDM_A_IND0 && s_reg.ptr0[7] |-> mem_we)
        else $error("port0 missed bank 0");
    ind1_bank_a: assert property (take_acc && i_acc_write && !i_acc_bit
        && i_acc_addr == `TDM_A_IND1 && s_reg.bank_sel |-> !mem_we)
        else $error("port1 bank 1 reached bank 0 RAM");
    unused_rd_a: assert property (plain_rd && in_eff == 9'h005
        |-> ##2 (o_acc_done && o_acc_rdata == `TDM_RD_NONE))
        else $error("unused location not zero");
    iar_dir_a: assert property (plain_rd && i_acc_addr == `TDM_A_IND0
        && (s_reg.ptr0 == `TDM_A_IND0 || s_reg.ptr0 == `TDM_A_IND1)
        |-> ##2 (o_acc_done && o_acc_rdata == `TDM_RD_NONE))
        else $error("indirect port read not zero");
    bit_op_a: assert property (take_acc && i_acc_bit |-> ##3 (o_acc_done
        && o_acc_rdata[$past(i_acc_bit_idx, 3)] == $past(i_acc_bit_set, 3)))
        else $error("bit operation result wrong");
    gp_wr_a: assert property (take_acc && i_acc_write && !i_acc_bit && i_acc_addr[7]
        |-> mem_we && mem_addr == i_acc_addr[6:0])
        else $error("direct RAM write lost");

    last_page_c: cover property (take_tab && tptr >= `TDM_PM_LAST_PAGE);
    bit_op_c: cover property (take_acc && i_acc_bit ##3 o_acc_done);
    ind1_c: cover property (plain_rd && i_acc_addr == `TDM_A_IND1 && s_reg.bank_sel);

endmodule

// file: testbench.sv
`timescale 1ns/10ps
`include "tdm_consts.svh"
module testbench;
    import tdm_pkg::*;
    localparam int TAB_CLKS = 8;
    localparam int CEILING = 3000;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_acc_valid = 1'b0;
    logic i_acc_write = 1'b0;
    logic [7:0] i_acc_addr = 8'h00;
    logic [7:0] i_acc_wdata = 8'h00;
    logic i_acc_bit = 1'b0;
    logic [2:0] i_acc_bit_idx = 3'h0;
    logic i_acc_bit_set = 1'b0;
    logic i_tab_start = 1'b0;
    logic [7:0] i_tab_dest = 8'h00;
    logic [14:0] i_pm_data;
    logic o_acc_done;
    logic [7:0] o_acc_rdata;
    logic o_tab_done;
    logic [10:0] o_pm_addr;
    logic o_pm_rd;
    logic o_busy;
    logic o_int_hold;
    logic [6:0] o_table_high;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    always #50 i_clk = ~i_clk;

    tdm_table_mem #(.TAB_CLKS(TAB_CLKS)) uut (
        .i_clk(i_clk), .i_srst(i_srst),
        .i_acc_valid(i_acc_valid), .i_acc_write(i_acc_write), .i_acc_addr(i_acc_addr),
        .i_acc_wdata(i_acc_wdata), .i_acc_bit(i_acc_bit), .i_acc_bit_idx(i_acc_bit_idx),
        .i_acc_bit_set(i_acc_bit_set), .o_acc_done(o_acc_done), .o_acc_rdata(o_acc_rdata),
        .i_tab_start(i_tab_start), .i_tab_dest(i_tab_dest), .o_tab_done(o_tab_done),
        .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd), .i_pm_data(i_pm_data),
        .o_busy(o_busy), .o_int_hold(o_int_hold), .o_table_high(o_table_high)
    );

    tdm_pm_model pm (.i_clk(i_clk), .i_rd(o_pm_rd), .i_addr(o_pm_addr), .o_data(i_pm_data));

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == CEILING) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Kind 0 read, 1 write, 2 bit op; latency is checked on every access
    task automatic acc(input int kind, input logic [7:0] a, input logic [7:0] d,
                       input logic [2:0] bi, input logic bs, output logic [7:0] r);
        int n;
        @(posedge i_clk);
        #1;
        i_acc_valid = 1'b1;
        i_acc_write = (kind == 1);
        i_acc_bit = (kind == 2);
        i_acc_addr = a;
        i_acc_wdata = d;
        i_acc_bit_idx = bi;
        i_acc_bit_set = bs;
        @(posedge i_clk);
        #1;
        i_acc_valid = 1'b0;
        n = 1;
        while (o_acc_done !== 1'b1 && n < 10) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk(16'(n), (kind == 1) ? 16'h0001 : ((kind == 0) ? 16'h0002 : 16'h0003));
        r = o_acc_rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        acc(1, a, d, 3'h0, 1'b0, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        acc(0, a, 8'h00, 3'h0, 1'b0, r);
        chk({8'h00, r}, {8'h00, e});
    endtask

    task automatic bitop(input logic [7:0] a, input logic [2:0] bi, input logic bs,
                         input logic [7:0] e);
        logic [7:0] r;
        acc(2, a, 8'h00, bi, bs, r);
        chk({8'h00, r}, {8'h00, e});
    endtask

    // Interrupts are not modelled, so no table read is ever pre-empted
    task automatic tab(input logic [7:0] dest, input logic [10:0] pa, input logic [6:0] hi,
                       input logic [7:0] lo);
        int n;
        @(posedge i_clk);
        #1;
        i_tab_start = 1'b1;
        i_tab_dest = dest;
        @(posedge i_clk);
        #1;
        i_tab_start = 1'b0;
        n = 1;
        chk({15'h0000, o_pm_rd}, 16'h0001);
        chk({5'h00, o_pm_addr}, {5'h00, pa});
        while (o_tab_done !== 1'b1 && n < 20) begin
            chk({15'h0000, o_int_hold}, 16'h0001);
            chk({15'h0000, o_busy}, 16'h0001);
            @(posedge i_clk);
            #1;
            n++;
        end
        chk(16'(n), 16'(TAB_CLKS));
        chk({9'h000, o_table_high}, {9'h000, hi});
        rd(dest, lo);
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        #1;
        i_srst = 1'b0;
        chk({9'h000, o_table_high}, 16'h0000);
        chk({15'h0000, o_busy}, 16'h0000);
        rd(`TDM_A_PTR0, 8'h00);
        wr(8'h80, 8'h3c);
        wr(8'hff, 8'hc3);
        rd(8'h80, 8'h3c);
        rd(8'hff, 8'hc3);
        bitop(8'h80, 3'h0, 1'b1, 8'h3d);
        bitop(8'h80, 3'h2, 1'b0, 8'h39);
        rd(8'h80, 8'h39);
        wr(8'h05, 8'h77);
        rd(8'h05, 8'h00);
        wr(`TDM_A_TAB_HIGH, 8'h55);
        rd(`TDM_A_TAB_HIGH, 8'h00);
        wr(`TDM_A_PTR0, 8'h85);
        wr(`TDM_A_IND0, 8'h5a);
        rd(8'h85, 8'h5a);
        rd(`TDM_A_IND0, 8'h5a);
        wr(`TDM_A_PTR0, `TDM_A_IND0);
        wr(`TDM_A_IND0, 8'h66);
        rd(`TDM_A_IND0, 8'h00);
        wr(`TDM_A_BANK, 8'h01);
        wr(`TDM_A_PTR1, 8'h85);
        wr(`TDM_A_IND1, 8'ha5);
        rd(`TDM_A_IND1, 8'h00);
        rd(8'h85, 8'h5a);
        wr(`TDM_A_BANK, 8'h00);
        rd(`TDM_A_IND1, 8'h5a);
        wr(`TDM_A_TBLP, 8'h06);
        wr(`TDM_A_TBHP, 8'h07);
        tab(8'h90, 11'h706, 7'h06, 8'hf9);
        wr(`TDM_A_TBLP, 8'h05);
        tab(8'h91, 11'h705, 7'h05, 8'hfa);
        wr(`TDM_A_TAB_HIGH, 8'h00);
        rd(`TDM_A_TAB_HIGH, 8'h05);
        chk({9'h000, o_table_high}, 16'h0005);
        conclude();
    end
endmodule
